// ===== common/sdram_pkg.sv
/*
  Shared constants for the four-bank ddr sdram device model: command
  codes, mode field positions, burst and latency codes, power states.
  Assumes nothing beyond a systemverilog elaborator.
*/
package sdram_pkg;

  // command pins {chip select, row strobe, column strobe, write enable}
  typedef enum logic [3:0] {
    CMD_MODE_LOAD = 4'h0,
    CMD_REFRESH   = 4'h1,
    CMD_PRECHARGE = 4'h2,
    CMD_ACTIVATE  = 4'h3,
    CMD_WRITE     = 4'h4,
    CMD_READ      = 4'h5,
    CMD_TRUNCATE  = 4'h6,
    CMD_NOOP      = 4'h7
  } cmd_t;

  typedef enum logic [1:0] {
    PWR_POWERUP = 2'h0,
    PWR_RUN     = 2'h1,
    PWR_SELF    = 2'h2
  } pwr_t;

  localparam int MODE_W = 14;
  localparam int BANKS  = 4;

  // mode register fields
  localparam int BL_LSB        = 0;
  localparam int BL_MSB        = 2;
  localparam int BT_BIT        = 3;
  localparam int CL_LSB        = 4;
  localparam int CL_MSB        = 6;
  localparam int DLL_RESET_BIT = 8;
  localparam int PREALL_BIT    = 10;

  localparam logic [2:0] BL2_CODE  = 3'h1;
  localparam logic [2:0] BL4_CODE  = 3'h2;
  localparam logic [2:0] BL8_CODE  = 3'h3;
  localparam logic [2:0] CL2_CODE  = 3'h2;
  localparam logic [2:0] CL25_CODE = 3'h6;
  localparam logic [2:0] CL3_CODE  = 3'h3;

  // whole-cycle latencies; the half cycle of 2.5 is rounded up here
  localparam logic [1:0] CL2_CYC  = 2'h2;
  localparam logic [1:0] CL3_CYC  = 2'h3;

  localparam logic [2:0] MASK_BL2 = 3'h1;
  localparam logic [2:0] MASK_BL4 = 3'h3;
  localparam logic [2:0] MASK_BL8 = 3'h7;

  localparam logic [1:0] BA_MODE = 2'h0;
  localparam logic [1:0] BA_EXT  = 2'h1;

endpackage

// ===== design/sdram_device.sv
/*
  Device side of a four-bank ddr sdram at command level, with a small
  data fifo between the array and the data pins.
  Assumes the controller drives the command pins on the same clk.
*/
// How it works
// - truncate ends latest read burst only
// - truncated read leaves its row open
// - refresh with gate low enters self refresh
// - data pins high impedance until first read
// - bank zero load writes mode, reset self-clears
// - mode reload leaves array contents intact
// - mode fields: length, type, latency, operating
// - lengths 2, 4, 8 in both types
// - bursts wrap inside aligned length block
// - sequential order counts up modulo length
// - interleaved order is start xor count
// - bank one load writes extended register
// - latency field picks 2 or 3; 2.5 rounds up to 3
// - no-op starts nothing new
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
module data_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             flush,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] store [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  wire              push = in_valid && in_ready;
  wire              pop  = out_valid && out_ready;

  assign in_ready  = (count_reg != (AW+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign out_data  = store[rd_ptr_reg];

  always_ff @(posedge clk) begin
    if (push) begin
      store[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || flush) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      wr_ptr_reg <= push ? wr_ptr_reg + 1'b1 : wr_ptr_reg;
      rd_ptr_reg <= pop ? rd_ptr_reg + 1'b1 : rd_ptr_reg;
      count_reg  <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////
module sdram_device import sdram_pkg::*; #(
  parameter int ROW_W      = 4,
  parameter int COL_W      = 6,
  parameter int DQ_W       = 8,
  parameter int FIFO_DEPTH = 16
) (
  // clock and reset
  input  wire logic                clk,
  input  wire logic                rst,
  // command pins
  input  wire logic                cke,
  input  wire logic                cs_n,
  input  wire logic                ras_n,
  input  wire logic                cas_n,
  input  wire logic                we_n,
  input  wire logic [1:0]          ba,
  input  wire logic [MODE_W-1:0]   addr,
  // data pins
  input  wire logic [DQ_W-1:0]     dq_i,
  output logic      [DQ_W-1:0]     dq_o,
  output logic                     dq_oe,
  input  wire logic                dqs_i,
  output logic                     dqs_o,
  output logic                     dqs_oe,
  // observation
  output logic      [MODE_W-1:0]   operating_mode_setup,
  output logic      [MODE_W-1:0]   extended_operating_setup,
  output logic                     self_refresh,
  output logic      [15:0]         refresh_count
);
  localparam int MEM_AW = 2 + ROW_W + COL_W;

  logic [DQ_W-1:0]   mem [2**MEM_AW];
  logic [MODE_W-1:0] mode_reg;
  logic [MODE_W-1:0] ext_reg;
  pwr_t              pwr_reg;
  pwr_t              pwr_next;
  logic              cke_prev_reg;
  logic [15:0]       refresh_count_reg;
  logic [ROW_W-1:0]  row_reg [BANKS];
  logic [BANKS-1:0]  open_reg;
  logic              gen_active_reg;
  logic              gen_write_reg;
  logic [2:0]        gen_idx_reg;
  logic [2:0]        gen_start_reg;
  logic [COL_W-1:0]  gen_col_reg;
  logic [1:0]        gen_bank_reg;
  logic [1:0]        lat_reg;
  logic              read_out_reg;
  logic [DQ_W-1:0]   dq_reg;
  logic              dq_oe_reg;
  logic              dqs_reg;

  ////////////////////////////////////////////////////////////////////////////
  // command decode
  wire cmd_t cmd       = cmd_t'({cs_n, ras_n, cas_n, we_n});
  wire       run       = (pwr_reg == PWR_RUN) && cke;
  wire       is_idle   = cs_n || (cmd == CMD_NOOP);
  wire       is_load   = run && !cs_n && (cmd == CMD_MODE_LOAD);
  wire       is_refr   = !cs_n && (cmd == CMD_REFRESH);
  wire       is_act    = run && !cs_n && (cmd == CMD_ACTIVATE);
  wire       is_pre    = run && !cs_n && (cmd == CMD_PRECHARGE);
  wire       is_read   = run && !cs_n && (cmd == CMD_READ);
  wire       is_write  = run && !cs_n && (cmd == CMD_WRITE);
  wire       is_trunc  = run && !cs_n && (cmd == CMD_TRUNCATE);
  wire       load_mode = is_load && (ba == BA_MODE);
  wire       load_ext  = is_load && (ba == BA_EXT);
  wire       auto_ref  = run && is_refr;
  wire       self_in   = (pwr_reg == PWR_RUN) && cke_prev_reg && !cke && is_refr;
  wire       self_out  = (pwr_reg == PWR_SELF) && cke && is_idle;

  ////////////////////////////////////////////////////////////////////////////
  // mode fields
  wire [2:0] bl_code  = mode_reg[BL_MSB:BL_LSB];
  wire       bt_intlv = mode_reg[BT_BIT];
  wire [2:0] cl_code  = mode_reg[CL_MSB:CL_LSB];
  // reserved length codes fall back to eight; programming them is forbidden
  wire [2:0] bl_mask  = (bl_code == BL2_CODE) ? MASK_BL2 :
                        (bl_code == BL4_CODE) ? MASK_BL4 : MASK_BL8;
  wire [1:0] cl_cyc   = (cl_code == CL2_CODE) ? CL2_CYC : CL3_CYC;

  ////////////////////////////////////////////////////////////////////////////
  // burst address generation
  wire [2:0] seq_low  = (gen_start_reg + gen_idx_reg) & bl_mask;
  wire [2:0] int_low  = (gen_start_reg ^ gen_idx_reg) & bl_mask;
  wire [2:0] cur_low  = bt_intlv ? int_low : seq_low;
  wire [COL_W-1:0] blk_mask = COL_W'(bl_mask);
  wire [COL_W-1:0] cur_col  = (gen_col_reg & ~blk_mask) | COL_W'(cur_low);
  wire [MEM_AW-1:0] cur_addr = {gen_bank_reg, row_reg[gen_bank_reg], cur_col};
  wire       fifo_in_ready;
  wire       fifo_out_valid;
  wire [DQ_W-1:0] fifo_out_data;
  wire       gen_step = gen_active_reg && (gen_write_reg ? dqs_i : fifo_in_ready);
  wire       gen_last = (gen_idx_reg == bl_mask);
  wire       mem_we   = gen_step && gen_write_reg;
  wire       push_rd  = gen_active_reg && !gen_write_reg;
  wire       flush    = is_read || is_trunc;
  wire       drain    = read_out_reg && (lat_reg == 2'h0) && fifo_out_valid && !flush;

  always_ff @(posedge clk) begin
    if (mem_we) begin
      mem[cur_addr] <= dq_i;
    end
  end

  data_fifo #(.WIDTH(DQ_W), .DEPTH(FIFO_DEPTH)) rd_fifo (
    .clk       (clk),
    .rst       (rst),
    .flush     (flush),
    .in_valid  (push_rd),
    .in_ready  (fifo_in_ready),
    .in_data   (mem[cur_addr]),
    .out_valid (fifo_out_valid),
    .out_ready (drain),
    .out_data  (fifo_out_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // per-bank open rows; truncation leaves them alone
  genvar b;
  generate
    for (b = 0; b < BANKS; b++) begin : g_bank
      wire hit = (ba == 2'(b));
      always_ff @(posedge clk) begin
        if (rst) begin
          open_reg[b] <= 1'b0;
          row_reg[b]  <= '0;
        end else if (is_act && hit) begin
          open_reg[b] <= 1'b1;
          row_reg[b]  <= addr[ROW_W-1:0];
        end else if (is_pre && (hit || addr[PREALL_BIT])) begin
          open_reg[b] <= 1'b0;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // mode registers; the lock-loop reset bit clears the cycle after loading
  always_ff @(posedge clk) begin
    if (rst) begin
      mode_reg <= '0;
      ext_reg  <= '0;
    end else begin
      if (load_mode) begin
        mode_reg <= addr;
      end else begin
        mode_reg[DLL_RESET_BIT] <= 1'b0;
      end
      if (load_ext) begin
        ext_reg <= addr;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // power state: outputs stay released until the gate first rises
  always_comb begin
    pwr_next = pwr_reg;
    unique case (pwr_reg)
      PWR_POWERUP: pwr_next = cke ? PWR_RUN : PWR_POWERUP;
      PWR_RUN:     pwr_next = self_in ? PWR_SELF : PWR_RUN;
      PWR_SELF:    pwr_next = self_out ? PWR_RUN : PWR_SELF;
      default:     pwr_next = PWR_POWERUP;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pwr_reg           <= PWR_POWERUP;
      cke_prev_reg      <= 1'b0;
      refresh_count_reg <= '0;
    end else begin
      pwr_reg           <= pwr_next;
      cke_prev_reg      <= cke;
      refresh_count_reg <= (auto_ref || self_in) ? refresh_count_reg + 16'h1 : refresh_count_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // burst sequencer; a new read or write replaces a running burst
  always_ff @(posedge clk) begin
    if (rst) begin
      gen_active_reg <= 1'b0;
      gen_write_reg  <= 1'b0;
      gen_idx_reg    <= '0;
      gen_start_reg  <= '0;
      gen_col_reg    <= '0;
      gen_bank_reg   <= '0;
    end else if (is_read || is_write) begin
      gen_active_reg <= 1'b1;
      gen_write_reg  <= is_write;
      gen_idx_reg    <= '0;
      gen_start_reg  <= addr[2:0] & bl_mask;
      gen_col_reg    <= addr[COL_W-1:0];
      gen_bank_reg   <= ba;
    end else if (is_trunc && !gen_write_reg) begin
      gen_active_reg <= 1'b0;
    end else if (gen_step) begin
      gen_active_reg <= !gen_last;
      gen_idx_reg    <= gen_idx_reg + 3'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read output: data leaves the fifo once the latency has run out
  always_ff @(posedge clk) begin
    if (rst) begin
      lat_reg      <= '0;
      read_out_reg <= 1'b0;
      dq_reg       <= '0;
      dq_oe_reg    <= 1'b0;
      dqs_reg      <= 1'b0;
    end else begin
      if (is_read) begin
        lat_reg      <= cl_cyc - 2'h1;
        read_out_reg <= 1'b1;
      end else begin
        lat_reg      <= (lat_reg != 2'h0) ? lat_reg - 2'h1 : lat_reg;
        read_out_reg <= read_out_reg && !is_trunc && !is_write &&
                        (gen_active_reg || fifo_out_valid);
      end
      dq_reg    <= drain ? fifo_out_data : dq_reg;
      dq_oe_reg <= drain;
      dqs_reg   <= drain ? !dqs_reg : 1'b0;
    end
  end

  assign dq_o                     = dq_reg;
  assign dq_oe                    = dq_oe_reg;
  assign dqs_o                    = dqs_reg;
  assign dqs_oe                   = dq_oe_reg;
  assign operating_mode_setup     = mode_reg;
  assign extended_operating_setup = ext_reg;
  assign self_refresh             = (pwr_reg == PWR_SELF);
  assign refresh_count            = refresh_count_reg;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  AST_TRUNC_STOPS: assert property (@(posedge clk) disable iff (rst)
    (is_trunc && gen_active_reg && !gen_write_reg) |=> (!gen_active_reg && !dq_oe_reg) [*2])
    else $error("truncate did not stop the read burst");

  AST_ROW_KEPT: assert property (@(posedge clk) disable iff (rst)
    is_trunc |=> $stable(open_reg))
    else $error("truncate changed an open row");

  AST_SELF_ENTRY: assert property (@(posedge clk) disable iff (rst)
    self_in |=> self_refresh ##0 (refresh_count == $past(refresh_count) + 16'h1))
    else $error("self refresh not entered");

  AST_HIGHZ_POWERUP: assert property (@(posedge clk) disable iff (rst)
    (pwr_reg == PWR_POWERUP) |-> !dq_oe && !dqs_oe)
    else $error("data pins driven during power-up");

  AST_MODE_LOAD: assert property (@(posedge clk) disable iff (rst)
    (load_mode && addr[DLL_RESET_BIT]) ##1 !load_mode
      |-> (operating_mode_setup[DLL_RESET_BIT] && operating_mode_setup[CL_MSB:0] == $past(addr[CL_MSB:0], 1))
      ##1 !operating_mode_setup[DLL_RESET_BIT])
    else $error("mode load or lock-loop reset clear wrong");

  AST_EXT_LOAD: assert property (@(posedge clk) disable iff (rst)
    load_ext |=> (extended_operating_setup == $past(addr)) && $stable(operating_mode_setup[CL_MSB:0]))
    else $error("extended load wrong");

  AST_NO_ARRAY_WRITE: assert property (@(posedge clk) disable iff (rst)
    (is_load && !gen_active_reg) |-> !mem_we)
    else $error("array written by a mode load");

  AST_LATENCY_TWO: assert property (@(posedge clk) disable iff (rst)
    (is_read && cl_code == CL2_CODE) ##1 is_idle ##1 is_idle |-> ##1 dq_oe)
    else $error("latency 2 data late");

  AST_BLOCK_WRAP: assert property (@(posedge clk) disable iff (rst)
    gen_active_reg |-> (cur_col & ~blk_mask) == (gen_col_reg & ~blk_mask))
    else $error("burst left its block");

  AST_SEQ_LAST: assert property (@(posedge clk) disable iff (rst)
    (gen_active_reg && !bt_intlv && gen_last) |-> (cur_low == ((gen_start_reg - 3'h1) & bl_mask)))
    else $error("sequential burst end wrong");

  AST_INTLV_SECOND: assert property (@(posedge clk) disable iff (rst)
    (gen_active_reg && bt_intlv && gen_idx_reg == 3'h1) |-> (cur_low == (gen_start_reg ^ 3'h1)))
    else $error("interleaved order wrong");

  AST_NOOP_IDLE: assert property (@(posedge clk) disable iff (rst)
    (is_idle && !gen_active_reg) |=> !gen_active_reg)
    else $error("no-op started a burst");
endmodule

// ===== verification/ctrl_model.sv
/*
  Controller-side model: drives the command pins and the write data pins.
  Assumes one shared clk and callers that serialise their task calls.
*/
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
module ctrl_model import sdram_pkg::*; (
  // clock
  input  wire logic         clk,
  // command pins
  output logic              cke,
  output logic              cs_n,
  output logic              ras_n,
  output logic              cas_n,
  output logic              we_n,
  output logic [1:0]        ba,
  output logic [MODE_W-1:0] addr,
  // write data
  output logic [7:0]        dq_i,
  output logic              dqs_i
);
  initial begin
    cke = 1'b0;  // gate held low through power-up
    {cs_n, ras_n, cas_n, we_n} = 4'hF;
    ba = 2'h0;
    addr = '0;
    dq_i = 8'h00;
    dqs_i = 1'b0;
  end

  // one command per call, held across its sampling edge, no-op after
  task automatic cmd(input cmd_t c, input logic [1:0] b, input logic [MODE_W-1:0] a, input logic gate);
    @(posedge clk);
    #1;
    {cs_n, ras_n, cas_n, we_n} = c;
    ba = b;
    addr = a;
    cke = gate;  // low together with a refresh asks for self refresh
    @(posedge clk);
    #1;
    {cs_n, ras_n, cas_n, we_n} = CMD_NOOP;  // idle slots carry no-ops
  endtask

  // eight-element write; the released bus is inverted so no stale value lingers
  task automatic wr(input logic [1:0] b, input logic [5:0] col, input logic [63:0] d);
    cmd(CMD_WRITE, b, {8'h00, col}, 1'b1);
    for (int i = 0; i < 8; i++) begin
      dqs_i = 1'b1;
      dq_i = d[8*i +: 8];
      @(posedge clk);
      #1;
    end
    dqs_i = 1'b0;
    dq_i = ~dq_i;
  endtask
endmodule

// ===== verification/tb_sdram_device.sv
/*
  Self-checking bench for the sdram device model and its data fifo.
  Assumes sdram_pkg, the design file and ctrl_model are compiled first.
*/
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
module tb_sdram_device import sdram_pkg::*; ();
  localparam int STABLE_CYC = 20000;  // 200 us of stable clock at 10 ns
  localparam int PRE_WAIT = 2;
  localparam int MRD_WAIT = 2;
  localparam int RFC_WAIT = 8;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cke, cs_n, ras_n, cas_n, we_n, dqs_i, dq_oe, dqs_o, dqs_oe, self_refresh;
  logic [1:0] ba;
  logic [MODE_W-1:0] addr, mode_q, ext_q;
  logic [7:0] dq_i, dq_o;
  logic seen;
  logic [15:0] ref_cnt;
  logic [15:0] rnd = 16'h54D8;
  logic [63:0] wd;
  logic [7:0] mem [64];
  logic [7:0] exp_q [$];
  logic [2:0] clc [3] = '{CL2_CODE, CL25_CODE, CL3_CODE};
  int cyc [3] = '{2, 3, 3};  // 2.5 rounds up to whole cycles in this model
  int err_total = 0;
  int checked = 0;

  always #5 clk = ~clk;

  sdram_device u_sdram_device (.clk(clk), .rst(rst), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
    .we_n(we_n), .ba(ba), .addr(addr), .dq_i(dq_i), .dq_o(dq_o), .dq_oe(dq_oe), .dqs_i(dqs_i),
    .dqs_o(dqs_o), .dqs_oe(dqs_oe), .operating_mode_setup(mode_q), .extended_operating_setup(ext_q),
    .self_refresh(self_refresh), .refresh_count(ref_cnt));
  ctrl_model u_ctrl_model (.clk(clk), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
    .we_n(we_n), .ba(ba), .addr(addr), .dq_i(dq_i), .dqs_i(dqs_i));

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] next_rnd(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk_data(input string n, input logic [7:0] e, input logic [7:0] s);
    checked++;
    if (s !== e) begin
      err_total++;
      $display("unexpected %s: expected %h, seen %h", n, e, s);
    end
  endtask
  task automatic chk_word(input string n, input logic [15:0] e, input logic [15:0] s);
    checked++;
    if (s !== e) begin
      err_total++;
      $display("unexpected %s: expected %h, seen %h", n, e, s);
    end
  endtask
  task automatic chk_flag(input string n, input logic e, input logic s);
    checked++;
    if (s !== e) begin
      err_total++;
      $display("unexpected %s: expected %b, seen %b", n, e, s);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic load(input logic [1:0] b, input logic [MODE_W-1:0] v);
    u_ctrl_model.cmd(CMD_MODE_LOAD, b, v, 1'b1);
    repeat (MRD_WAIT + 3) @(posedge clk);
    #1;
  endtask
  // notes the expected burst, then checks dq_oe low one edge before the latency and high at it
  task automatic rd(input logic [5:0] st, input int bl, input logic bt, input int lat, input bit full);
    logic [5:0] m;
    logic [5:0] o;
    m = 6'(bl - 1);
    for (int i = 0; i < bl; i++) begin
      o = bt ? ((st ^ 6'(i)) & m) : ((st + 6'(i)) & m);
      exp_q.push_back(mem[(st & ~m) | o]);
    end
    u_ctrl_model.cmd(CMD_READ, 2'h0, {8'h00, st}, 1'b1);
    repeat (lat - 1) @(posedge clk);
    #1;
    chk_flag("dq_oe_early", 1'b0, dq_oe);
    @(posedge clk);
    #1;
    chk_flag("dq_oe_first", 1'b1, dq_oe);
    if (full) repeat (bl + 2) @(posedge clk);
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // outputs are sampled before this edge's updates land
  always @(posedge clk) begin
    if (dq_oe === 1'b1) begin
      chk_flag("dqs_oe", 1'b1, dqs_oe);
      if (exp_q.size() == 0) chk_flag("dq_oe_idle", 1'b0, dq_oe);
      else chk_data("dq_o", exp_q.pop_front(), dq_o);
    end
  end

  initial begin
    repeat (100000) @(posedge clk);
    err_total++;
    $display("unexpected run: expected end, seen timeout");
    end_sim();
  end

  initial begin
    repeat (5) @(posedge clk);
    #1;
    rst = 1'b0;
    u_ctrl_model.cmd(CMD_READ, 2'h0, 14'h0000, 1'b0);  // ignored while still gated
    repeat (STABLE_CYC) @(posedge clk);
    #1;
    chk_flag("dq_oe", 1'b0, dq_oe);
    chk_flag("dqs_oe", 1'b0, dqs_oe);
    u_ctrl_model.cmd(CMD_NOOP, 2'h0, 14'h0000, 1'b1);
    u_ctrl_model.cmd(CMD_PRECHARGE, 2'h0, 14'h0400, 1'b1);
    repeat (PRE_WAIT) @(posedge clk);
    load(BA_EXT, 14'h0002);
    chk_word("ext_reg", 16'h0002, {2'h0, ext_q});
    chk_word("mode_reg", 16'h0000, {2'h0, mode_q});
    u_ctrl_model.cmd(CMD_MODE_LOAD, BA_MODE, 14'h0122, 1'b1);
    seen = 1'b0;
    repeat (3) begin
      if (mode_q === 14'h0122) seen = 1'b1;
      @(posedge clk);
      #1;
    end
    chk_flag("lock_loop_set", 1'b1, seen);
    chk_word("mode_reg", 16'h0022, {2'h0, mode_q});
    u_ctrl_model.cmd(CMD_PRECHARGE, 2'h0, 14'h0400, 1'b1);
    repeat (PRE_WAIT) @(posedge clk);
    repeat (2) begin
      u_ctrl_model.cmd(CMD_REFRESH, 2'h0, 14'h0000, 1'b1);
      repeat (RFC_WAIT) @(posedge clk);
    end
    #1;
    chk_word("refresh_count", 16'h0002, ref_cnt);
    load(BA_MODE, 14'h0022);  // same parameters, lock-loop reset low
    chk_word("mode_reg", 16'h0022, {2'h0, mode_q});
    repeat (200) @(posedge clk);
    load(BA_MODE, {7'h00, CL2_CODE, 1'b0, BL8_CODE});
    u_ctrl_model.cmd(CMD_ACTIVATE, 2'h0, 14'h0001, 1'b1);
    for (int k = 0; k < 8; k++) begin
      for (int i = 0; i < 8; i++) begin
        rnd = next_rnd(rnd);
        mem[8*k+i] = rnd[7:0];
        wd[8*i +: 8] = rnd[7:0];
      end
      u_ctrl_model.wr(2'h0, 6'(8*k), wd);
    end
    u_ctrl_model.cmd(CMD_PRECHARGE, 2'h0, 14'h0400, 1'b1);
    // every length in both orders, latency codes cycled, random start column
    for (int t = 0; t < 6; t++) begin
      rnd = next_rnd(rnd);
      load(BA_MODE, {7'h00, clc[t%3], t[0], (t < 2) ? BL2_CODE : (t < 4) ? BL4_CODE : BL8_CODE});
      u_ctrl_model.cmd(CMD_ACTIVATE, 2'h0, 14'h0001, 1'b1);
      rd(rnd[5:0], 2 << (t / 2), t[0], cyc[t%3], 1'b1);
      u_ctrl_model.cmd(CMD_PRECHARGE, 2'h0, 14'h0400, 1'b1);
      repeat (PRE_WAIT) @(posedge clk);
    end
    load(BA_MODE, {7'h00, CL2_CODE, 1'b0, BL8_CODE});
    u_ctrl_model.cmd(CMD_ACTIVATE, 2'h0, 14'h0001, 1'b1);
    rd(6'h05, 8, 1'b0, 2, 1'b0);
    u_ctrl_model.cmd(CMD_TRUNCATE, 2'h0, 14'h0000, 1'b1);
    repeat (2) begin
      @(posedge clk);
      #1;
      chk_flag("dq_oe_truncated", 1'b0, dq_oe);
    end
    exp_q.delete();
    rd(6'h05, 8, 1'b0, 2, 1'b1);
    u_ctrl_model.cmd(CMD_PRECHARGE, 2'h0, 14'h0400, 1'b1);
    repeat (PRE_WAIT) @(posedge clk);
    u_ctrl_model.cmd(CMD_REFRESH, 2'h0, 14'h0000, 1'b0);
    chk_flag("self_refresh", 1'b1, self_refresh);
    chk_word("refresh_count", 16'h0003, ref_cnt);
    u_ctrl_model.cmd(CMD_MODE_LOAD, BA_MODE, 14'h0033, 1'b0);  // asleep, must be ignored
    u_ctrl_model.cmd(CMD_NOOP, 2'h0, 14'h0000, 1'b1);
    chk_flag("self_refresh", 1'b0, self_refresh);
    chk_word("mode_reg", 16'h0023, {2'h0, mode_q});
    repeat (200) @(posedge clk);
    u_ctrl_model.cmd(CMD_ACTIVATE, 2'h0, 14'h0001, 1'b1);
    rd(6'h00, 8, 1'b0, 2, 1'b1);
    // fifo seen from the pins: random interleaved burst at the longest latency, then released
    u_ctrl_model.cmd(CMD_PRECHARGE, 2'h0, 14'h0400, 1'b1);
    repeat (PRE_WAIT) @(posedge clk);
    load(BA_MODE, {7'h00, CL3_CODE, 1'b1, BL8_CODE});
    u_ctrl_model.cmd(CMD_ACTIVATE, 2'h0, 14'h0001, 1'b1);
    rnd = next_rnd(rnd);
    rd(rnd[5:0], 8, 1'b1, 3, 1'b1);
    chk_flag("drained_dq_oe", 1'b0, dq_oe);
    chk_flag("drained_dqs_o", 1'b0, dqs_o);
    chk_flag("drained_dqs_oe", 1'b0, dqs_oe);
    chk_word("mode_reg", 16'h003B, {2'h0, mode_q});
    chk_word("ext_reg", 16'h0002, {2'h0, ext_q});
    chk_word("reads_left", 16'h0000, 16'(exp_q.size()));
    end_sim();
  end
endmodule
